// *** rtl/pfm_defs.vh ***
// Purpose: shared constants for the port F pin function mux
// Assumes: plain Verilog-2005, included by bare name
// Notes: function select codes are two bits per pin
`ifndef PFM_DEFS_VH
`define PFM_DEFS_VH
`define PFM_NPINS 8
`define PFM_SELW 2
`define PFM_FN_GPIO 2'h0
`define PFM_FN_ALT1 2'h1
`define PFM_FN_ALT2 2'h2
`define PFM_SEL_RST 16'h0000
`define PFM_DIR_RST 8'h00
`define PFM_DATA_RST 8'h00
`define PFM_PULL_RST 8'hFF
`define PFM_CKSEL_W 2
`define PFM_CKDIV_RST 2'h0
`endif

// *** rtl/pfm_clock_output_select_register_gen.v ***
// Purpose: buffered clock output source for port F line 1
// Assumes: sources are synchronous level streams in the clk domain
// Notes: output is registered, so it lags its source by one clock
`include "pfm_defs.vh"
module pfm_clock_output_select_register_gen
(
   // clock and reset
   input wire clk,
   input wire rst,
   // source choice and candidate sources
   input wire [`PFM_CKSEL_W-1:0] clock_out_source_select,
   input wire [3:0] clk_sources,
   // buffered result
   output reg buffered_clock_out_r
);
   // register the picked source so the pin never sees a mux glitch
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         buffered_clock_out_r <= 1'b0;
      else
         buffered_clock_out_r <= clk_sources[clock_out_source_select];
   end
endmodule

// *** rtl/pfm_ext_clk_sel.v ***
// Purpose: decides when the dedicated pin feeds the external clock
// Assumes: select bits are register levels in the clk domain
// Notes: crystal power-down stays a software choice
`include "pfm_defs.vh"
module pfm_ext_clk_sel
(
   // clock and reset
   input wire clk,
   input wire rst,
   // select bits
   input wire port_c_bit0_function_select,
   input wire external_clock_select_bit,
   // result
   output reg ext_clock_in_use_r
);
   // both bits are needed; either alone keeps the internal source
   always @(posedge clk or posedge rst)
   begin
      if (rst)
         ext_clock_in_use_r <= 1'b0;
      else
         ext_clock_in_use_r <= port_c_bit0_function_select &
            external_clock_select_bit;
   end
endmodule

// *** rtl/pfm_port_f_mux.v ***
// Purpose: pin function mux for the eight port F lines
// Assumes: all inputs synchronous to clk; pads resolve the enables
// Notes: oe_n low means drive; open-drain lines only drive low
`include "pfm_defs.vh"
module pfm_port_f_mux
#(
   parameter NPINS = `PFM_NPINS
)
(
   // clock and reset
   input wire clk,
   input wire rst,
   // software configuration, line n uses sel bits [2n-1:2n-2]
   input wire [2*NPINS-1:0] pin_func_sel,
   input wire [NPINS-1:0] gpio_dir,
   input wire [NPINS-1:0] gpio_out_data,
   input wire [NPINS-1:0] pull_enable,
   input wire [`PFM_CKSEL_W-1:0] clock_out_source_select,
   input wire [3:0] clk_sources,
   input wire serial1_single_wire,
   input wire port_c_bit0_function_select,
   input wire external_clock_select_bit,
   // pads
   input wire [NPINS-1:0] pad_in,
   output reg [NPINS-1:0] pad_out_r,
   output reg [NPINS-1:0] pad_oe_n_r,
   output reg [NPINS-1:0] pad_pull_r,
   // peripheral outputs toward the pins
   input wire crossbar_output_2,
   input wire crossbar_output_3,
   input wire crossbar_output_4,
   input wire crossbar_output_5,
   input wire i2c_bus1_clock_drive_low,
   input wire i2c_bus1_data_drive_low,
   input wire serial1_transmit,
   input wire serial1_tx_enable,
   input wire timer_b_channel1_out,
   input wire timer_b_channel1_oe,
   input wire timer_b_channel2_out,
   input wire timer_b_channel2_oe,
   input wire timer_b_channel3_out,
   input wire timer_b_channel3_oe,
   input wire pwm_sub3_x_channel_out,
   input wire pwm_sub3_x_channel_oe,
   // pin levels toward peripherals and software
   output reg [NPINS-1:0] gpio_in_data_r,
   output reg crossbar_input_7_r,
   output reg i2c_bus1_clock_in_r,
   output reg i2c_bus1_data_in_r,
   output reg serial1_receive_r,
   output reg serial0_receive_r,
   output reg timer_b_channel1_in_r,
   output reg timer_b_channel2_in_r,
   output reg timer_b_channel3_in_r,
   output reg pwm_sub3_x_capture_r,
   // clock status
   output reg buffered_clock_out_r,
   output reg ext_clock_in_use_r
);
   wire buffered_clock_out_w;
   wire ext_w;
   reg [NPINS-1:0] out_nxt;
   reg [NPINS-1:0] oe_n_nxt;
   reg [1:0] f1, f2, f3, f4, f5, f6, f7, f8;

   // select code of one line
   function [`PFM_SELW-1:0] fsel;
      input [2*NPINS-1:0] sel;
      input integer idx;
      begin
         fsel = sel[idx*`PFM_SELW +: `PFM_SELW];
      end
   endfunction

   // clock output source, a registered pick
   pfm_clock_output_select_register_gen u_buffered_clock_out
   (
      .clk(clk),
      .rst(rst),
      .clock_out_source_select(clock_out_source_select),
      .clk_sources(clk_sources),
      .buffered_clock_out_r(buffered_clock_out_w)
   );

   // external clock qualification
   pfm_ext_clk_sel u_ext
   (
      .clk(clk),
      .rst(rst),
      .port_c_bit0_function_select(port_c_bit0_function_select),
      .external_clock_select_bit(external_clock_select_bit),
      .ext_clock_in_use_r(ext_w)
   );

   // output mux per line; an undefined code falls back to general use
   always @*
   begin
      f1 = fsel(pin_func_sel, 0);
      f2 = fsel(pin_func_sel, 1);
      f3 = fsel(pin_func_sel, 2);
      f4 = fsel(pin_func_sel, 3);
      f5 = fsel(pin_func_sel, 4);
      f6 = fsel(pin_func_sel, 5);
      f7 = fsel(pin_func_sel, 6);
      f8 = fsel(pin_func_sel, 7);
      out_nxt = gpio_out_data;
      oe_n_nxt = ~gpio_dir;
      // line 1: buffered clock out, or crossbar input (line undriven)
      if (f1 == `PFM_FN_ALT1)
      begin
         out_nxt[0] = buffered_clock_out_w;
         oe_n_nxt[0] = 1'b0;
      end
      else if (f1 == `PFM_FN_ALT2)
         oe_n_nxt[0] = 1'b1;
      // line 2: open drain clock drives only low
      if (f2 == `PFM_FN_ALT1)
      begin
         out_nxt[1] = 1'b0;
         oe_n_nxt[1] = ~i2c_bus1_clock_drive_low;
      end
      else if (f2 == `PFM_FN_ALT2)
      begin
         out_nxt[1] = crossbar_output_2;
         oe_n_nxt[1] = 1'b0;
      end
      // line 3: open drain data drives only low
      if (f3 == `PFM_FN_ALT1)
      begin
         out_nxt[2] = 1'b0;
         oe_n_nxt[2] = ~i2c_bus1_data_drive_low;
      end
      else if (f3 == `PFM_FN_ALT2)
      begin
         out_nxt[2] = crossbar_output_3;
         oe_n_nxt[2] = 1'b0;
      end
      // line 4: single wire releases the pin while not transmitting
      if (f4 == `PFM_FN_ALT1)
      begin
         out_nxt[3] = serial1_transmit;
         oe_n_nxt[3] = serial1_single_wire & ~serial1_tx_enable;
      end
      else if (f4 == `PFM_FN_ALT2)
      begin
         out_nxt[3] = crossbar_output_4;
         oe_n_nxt[3] = 1'b0;
      end
      // line 5: receive input, or crossbar output
      if (f5 == `PFM_FN_ALT1)
         oe_n_nxt[4] = 1'b1;
      else if (f5 == `PFM_FN_ALT2)
      begin
         out_nxt[4] = crossbar_output_5;
         oe_n_nxt[4] = 1'b0;
      end
      // line 6: timer channel 2 or pwm x, each with its own enable
      if (f6 == `PFM_FN_ALT1)
      begin
         out_nxt[5] = timer_b_channel2_out;
         oe_n_nxt[5] = ~timer_b_channel2_oe;
      end
      else if (f6 == `PFM_FN_ALT2)
      begin
         out_nxt[5] = pwm_sub3_x_channel_out;
         oe_n_nxt[5] = ~pwm_sub3_x_channel_oe;
      end
      // line 7: timer channel 3 only
      if (f7 == `PFM_FN_ALT1)
      begin
         out_nxt[6] = timer_b_channel3_out;
         oe_n_nxt[6] = ~timer_b_channel3_oe;
      end
      // line 8: serial 0 receive or timer channel 1
      if (f8 == `PFM_FN_ALT1)
         oe_n_nxt[7] = 1'b1;
      else if (f8 == `PFM_FN_ALT2)
      begin
         out_nxt[7] = timer_b_channel1_out;
         oe_n_nxt[7] = ~timer_b_channel1_oe;
      end
   end

   // pad drive; reset leaves every line an undriven, pulled-up input
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pad_out_r <= `PFM_DATA_RST;
         pad_oe_n_r <= ~`PFM_DIR_RST;
         pad_pull_r <= `PFM_PULL_RST;
      end
      else
      begin
         pad_out_r <= out_nxt;
         pad_oe_n_r <= oe_n_nxt;
         pad_pull_r <= pull_enable & oe_n_nxt; // pull only when released
      end
   end

   // input routing; peripherals see the pin only when selected,
   // otherwise an idle level: high for i2c and serial receive, low for crossbar, timer and pwm
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         gpio_in_data_r <= `PFM_DATA_RST;
         crossbar_input_7_r <= 1'b0;
         i2c_bus1_clock_in_r <= 1'b1;
         i2c_bus1_data_in_r <= 1'b1;
         serial1_receive_r <= 1'b1;
         serial0_receive_r <= 1'b1;
         timer_b_channel1_in_r <= 1'b0;
         timer_b_channel2_in_r <= 1'b0;
         timer_b_channel3_in_r <= 1'b0;
         pwm_sub3_x_capture_r <= 1'b0;
         buffered_clock_out_r <= 1'b0;
         ext_clock_in_use_r <= 1'b0;
      end
      else
      begin
         gpio_in_data_r <= pad_in;
         crossbar_input_7_r <= (f1 == `PFM_FN_ALT2) & pad_in[0];
         i2c_bus1_clock_in_r <= (f2 != `PFM_FN_ALT1) | pad_in[1];
         i2c_bus1_data_in_r <= (f3 != `PFM_FN_ALT1) | pad_in[2];
         serial1_receive_r <= (f5 == `PFM_FN_ALT1) ? pad_in[4] :
            ((f4 == `PFM_FN_ALT1) & serial1_single_wire) ? pad_in[3] :
            1'b1;
         serial0_receive_r <= (f8 != `PFM_FN_ALT1) | pad_in[7];
         timer_b_channel1_in_r <= (f8 == `PFM_FN_ALT2) & pad_in[7];
         timer_b_channel2_in_r <= (f6 == `PFM_FN_ALT1) & pad_in[5];
         timer_b_channel3_in_r <= (f7 == `PFM_FN_ALT1) & pad_in[6];
         pwm_sub3_x_capture_r <= (f6 == `PFM_FN_ALT2) & pad_in[5];
         buffered_clock_out_r <= buffered_clock_out_w;
         ext_clock_in_use_r <= ext_w;
      end
   end
endmodule

// *** bench/pfm_port_f_mux_props.sv ***
// Purpose: concurrent checks on the port F pin mux ports
// Assumes: one clock domain, async active-high reset
// Notes: bound from the bench top, watches design inputs and outputs
module pfm_port_f_mux_props
#(
   parameter NPINS = 8
)
(
   // clock and reset
   input wire clk,
   input wire rst,
   // configuration and peripheral levels
   input wire [2*NPINS-1:0] pin_func_sel,
   input wire [NPINS-1:0] gpio_dir,
   input wire [NPINS-1:0] gpio_out_data,
   input wire [1:0] clock_out_source_select,
   input wire [3:0] clk_sources,
   input wire port_c_bit0_function_select,
   input wire external_clock_select_bit,
   input wire i2c_bus1_clock_drive_low,
   input wire i2c_bus1_data_drive_low,
   input wire crossbar_output_4,
   // design outputs
   input wire [NPINS-1:0] pad_out_r,
   input wire [NPINS-1:0] pad_oe_n_r,
   input wire [NPINS-1:0] pad_pull_r,
   input wire buffered_clock_out_r,
   input wire ext_clock_in_use_r
);
   // selected source; select is held so its own latency does not matter
   wire pick = clk_sources[clock_out_source_select];
   wire both = port_c_bit0_function_select & external_clock_select_bit;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   reset_state_a: assert property ($fell(rst) |-> &pad_oe_n_r && &pad_pull_r)
      else $error("pads not pulled-up inputs at reset release");
   // !rst in each antecedent but reset_state_a: an attempt begun on the release edge would
   // otherwise compare the reset value against the random inputs
   gpio_dir_a: assert property (!rst && pin_func_sel[15] == pin_func_sel[14] |=>
      pad_oe_n_r[7] == !$past(gpio_dir[7])) else $error("line 8 direction wrong");
   gpio_data_a: assert property (!rst && pin_func_sel[5:4] == 2'h0 && gpio_dir[2] |=>
      pad_out_r[2] == $past(gpio_out_data[2])) else $error("line 3 data wrong");
   i2c_clk_a: assert property (!rst && pin_func_sel[3:2] == 2'h1 |=>
      pad_oe_n_r[1] == !$past(i2c_bus1_clock_drive_low) && !pad_out_r[1])
      else $error("line 2 not open-drain clock");
   i2c_dat_a: assert property (!rst && pin_func_sel[5:4] == 2'h1 |=>
      pad_oe_n_r[2] == !$past(i2c_bus1_data_drive_low) && !pad_out_r[2])
      else $error("line 3 not open-drain data");
   xbar_out_a: assert property (!rst && pin_func_sel[7:6] == 2'h2 |=>
      !pad_oe_n_r[3] && pad_out_r[3] == $past(crossbar_output_4))
      else $error("line 4 crossbar output wrong");
   ext_on_a: assert property ((!rst && both) [*3] |-> ext_clock_in_use_r)
      else $error("external clock not taken with both bits set");
   ext_off_a: assert property ((!rst && !both) [*3] |-> !ext_clock_in_use_r)
      else $error("external clock taken without both bits");
   clk_out_a: assert property ((!rst && $stable(clock_out_source_select)) [*3] |->
      buffered_clock_out_r == $past(pick, 2)) else $error("clock out wrong");
   cover property (both [*3]);
   cover property (pin_func_sel[3:2] == 2'h1 && i2c_bus1_clock_drive_low);
   cover property ($fell(rst));
endmodule

// *** bench/test_port_f_pin_function_mux.sv ***
// Purpose: random and corner checks of the port F pin mux
// Assumes: inputs held three cycles before outputs are judged
// Notes: pad data is masked where the line is released, level is free
module test_port_f_pin_function_mux;
   timeunit 1ns;
   timeprecision 1ps;
   // clock, reset and inputs
   logic clk, rst;
   logic [15:0] pin_func_sel;
   logic [7:0] gpio_dir, gpio_out_data, pull_enable, pad_in;
   logic [1:0] clock_out_source_select;
   logic [3:0] clk_sources;
   logic serial1_single_wire, port_c_bit0_function_select;
   logic external_clock_select_bit, crossbar_output_2, crossbar_output_3;
   logic crossbar_output_4, crossbar_output_5, i2c_bus1_clock_drive_low;
   logic i2c_bus1_data_drive_low, serial1_transmit, serial1_tx_enable;
   logic timer_b_channel1_out, timer_b_channel1_oe, timer_b_channel2_out;
   logic timer_b_channel2_oe, timer_b_channel3_out, timer_b_channel3_oe;
   logic pwm_sub3_x_channel_out, pwm_sub3_x_channel_oe;
   // design outputs
   wire [7:0] pad_out_r, pad_oe_n_r, pad_pull_r, gpio_in_data_r;
   wire crossbar_input_7_r, i2c_bus1_clock_in_r, i2c_bus1_data_in_r;
   wire serial1_receive_r, serial0_receive_r, timer_b_channel1_in_r;
   wire timer_b_channel2_in_r, timer_b_channel3_in_r, pwm_sub3_x_capture_r;
   wire buffered_clock_out_r, ext_clock_in_use_r;
   int fails, checked;
   logic [72:0] v;
   logic [15:0] e;
   logic [15:0] pats [4] = '{16'hFFFF, 16'h5555, 16'hAAAA, 16'h0000};

   pfm_port_f_mux pfm_port_f_mux_i (.*);

   // free-running 50 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // all inputs from one vector, so a test changes them in one step
   task automatic setall(input logic [72:0] x);
      {pin_func_sel, gpio_dir, gpio_out_data, pull_enable, pad_in,
       clock_out_source_select, clk_sources, serial1_single_wire,
       port_c_bit0_function_select, external_clock_select_bit,
       crossbar_output_2, crossbar_output_3, crossbar_output_4,
       crossbar_output_5, i2c_bus1_clock_drive_low, i2c_bus1_data_drive_low,
       serial1_transmit, serial1_tx_enable, timer_b_channel1_out,
       timer_b_channel1_oe, timer_b_channel2_out, timer_b_channel2_oe,
       timer_b_channel3_out, timer_b_channel3_oe, pwm_sub3_x_channel_out,
       pwm_sub3_x_channel_oe} <= x;
   endtask

   // expected {oe_n, out}; codes 3 and line 7 code 2 fall back to gpio
   function automatic logic [15:0] exp_pad();
      logic [7:0] o, d;
      o = ~gpio_dir;
      d = gpio_out_data;
      for (int n = 0; n < 8; n++)
      begin
         case ({3'(n), pin_func_sel[2*n +: 2]})
            5'h01: {o[n], d[n]} = {1'b0, clk_sources[clock_out_source_select]};
            5'h02, 5'h11, 5'h1D: {o[n], d[n]} = 2'h2;
            5'h05: {o[n], d[n]} = {~i2c_bus1_clock_drive_low, 1'b0};
            5'h06: {o[n], d[n]} = {1'b0, crossbar_output_2};
            5'h09: {o[n], d[n]} = {~i2c_bus1_data_drive_low, 1'b0};
            5'h0A: {o[n], d[n]} = {1'b0, crossbar_output_3};
            5'h0D: {o[n], d[n]} = {serial1_single_wire & ~serial1_tx_enable,
                                   serial1_transmit};
            5'h0E: {o[n], d[n]} = {1'b0, crossbar_output_4};
            5'h12: {o[n], d[n]} = {1'b0, crossbar_output_5};
            5'h15: {o[n], d[n]} = {~timer_b_channel2_oe, timer_b_channel2_out};
            5'h16: {o[n], d[n]} = {~pwm_sub3_x_channel_oe, pwm_sub3_x_channel_out};
            5'h19: {o[n], d[n]} = {~timer_b_channel3_oe, timer_b_channel3_out};
            5'h1E: {o[n], d[n]} = {~timer_b_channel1_oe, timer_b_channel1_out};
            default: ;
         endcase
      end
      return {o, d};
   endfunction

   // expected routed inputs; unselected peripherals read their idle level
   function automatic logic [10:0] exp_in();
      logic [1:0] s1, s2, s3, s4, s5, s6, s7, s8;
      {s8, s7, s6, s5, s4, s3, s2, s1} = pin_func_sel;
      return {s1 == 2'h2 & pad_in[0],
              s2 != 2'h1 | pad_in[1],
              s3 != 2'h1 | pad_in[2],
              s5 == 2'h1 ? pad_in[4] :
                 (s4 == 2'h1 & serial1_single_wire) ? pad_in[3] : 1'b1,
              s8 != 2'h1 | pad_in[7],
              s8 == 2'h2 & pad_in[7],
              s6 == 2'h1 & pad_in[5],
              s7 == 2'h1 & pad_in[6],
              s6 == 2'h2 & pad_in[5],
              clk_sources[clock_out_source_select],
              port_c_bit0_function_select & external_clock_select_bit};
   endfunction

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic test_done();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // reset, corner select patterns, then random configurations
   initial
   begin
      fails = 0;
      checked = 0;
      rst = 1'b1;
      setall('0);
      void'($urandom(35));
      repeat (11) @(posedge clk);
      @(negedge clk);
      cmp({pad_oe_n_r, pad_pull_r}, 16'hFFFF);
      @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(negedge clk);
      cmp({8'h00, pad_oe_n_r}, 16'h00FF);
      for (int i = 0; i < 120; i++)
      begin
         v = 73'({$urandom, $urandom, $urandom});
         if (i < 4)
            v[72:57] = pats[i];
         @(posedge clk);
         setall(v);
         if (i == 60)
         begin
            rst <= 1'b1;
            repeat (2) @(negedge clk);
            cmp({pad_oe_n_r, pad_pull_r}, 16'hFFFF);
            @(posedge clk);
            rst <= 1'b0;
         end
         repeat (3) @(posedge clk);
         @(negedge clk);
         e = exp_pad();
         cmp({pad_oe_n_r, pad_out_r | e[15:8]}, {e[15:8], e[7:0] | e[15:8]});
         cmp({pad_pull_r, gpio_in_data_r}, {pull_enable & e[15:8], pad_in});
         // crystal power-down with the external clock is left to software
         cmp({5'h00, crossbar_input_7_r, i2c_bus1_clock_in_r,
              i2c_bus1_data_in_r, serial1_receive_r, serial0_receive_r,
              timer_b_channel1_in_r, timer_b_channel2_in_r,
              timer_b_channel3_in_r, pwm_sub3_x_capture_r,
              buffered_clock_out_r, ext_clock_in_use_r},
             {5'h00, exp_in()});
         $display("test %0d done", i);
      end
      test_done();
   end
endmodule

bind pfm_port_f_mux pfm_port_f_mux_props #(.NPINS(NPINS)) pfm_port_f_mux_props_i (.*);
